//--- rtl/ssp_device.sv
// synthesizer digital core: serial latches, dividers, detector, pump control
// Contract
// - shift 18 bits on clock rise, msb first
// - strobe rise copies data by select bit
// - reference register field positions
// - host writes reserved bit as zero
// - host keeps reference ratio 2 to 1023
// - float bit floats pump and comparator; code floats the pump only, not in test mode
// - host sets float whenever test mode set
// - polarity bit picks pump direction
// - test mode routes divider output to pump
// - feedback register field positions
// - host keeps main and swallow counts legal
// - swallow cycles modulus 33, rest 32
// - detector drives up, down or float
// - minimum width pulses, no dead zone
// - control pair decodes four modes
// - sync power down waits pump pulse
// - async power down acts at once
// - chip enable low powers down, floats
// - counter reset clears both, aligned restart
// - power down holds counters at zero
// - power down stops dividers, floats pump
// - serial latching works while powered down
`timescale 1ns/100ps
`default_nettype none
module ssp_device (
    input  wire logic pclk,         // system clock, 50 MHz
    input  wire logic presetn,      // async reset, active low
    ssp_link_if.dev   link,         // serial programming link
    input  wire logic ref_in,       // reference oscillator input
    input  wire logic vco_in,       // vco input to prescaler
    output logic      pump_out_q,   // pump pin level, 1 toward supply
    output logic      pump_oe_q,    // pump pin driven
    output logic      pump_src_q,   // pump-up switch on
    output logic      pump_snk_q,   // pump-down switch on
    output logic      ref_pulse_q,  // reference divider output pulse
    output logic      fb_pulse_q,   // feedback divider output pulse
    output logic      powered_q     // core is running
);
    localparam int I_SCK = 0;
    localparam int I_SDI = 1;
    localparam int I_STB = 2;
    localparam int I_CE  = 3;
    localparam int I_REF = 4;
    localparam int I_VCO = 5;
    localparam int NSYNC = 6;
    logic [NSYNC-1:0]              s1_q;
    logic [NSYNC-1:0]              s2_q;
    logic [NSYNC-1:0]              prev_q;
    logic [NSYNC-1:0]              pin_in;
    logic [NSYNC-1:0]              rise;
    logic [ssp_pkg::SR_W-1:0]      shift_q;
    logic [ssp_pkg::DATA_W-1:0]    fb_q;
    logic [ssp_pkg::REF_W-1:0]     ref_q;
    logic [ssp_pkg::DATA_W-1:0]    word_data;
    logic [1:0]                    ctl;
    logic                          async_pd;
    logic                          sync_req;
    logic                          cnt_clear;
    logic                          down_q;
    logic                          hold;
    logic [ssp_pkg::DIV_W-1:0]     ref_div;
    logic [ssp_pkg::DIV_W-1:0]     main_div;
    logic [ssp_pkg::DIV_W-1:0]     swal_ext;
    logic [ssp_pkg::DIV_W-1:0]     main_cnt;
    logic [ssp_pkg::PRE_W-1:0]     pre_mod;
    logic                          ref_wrap;
    logic                          pre_wrap;
    logic                          fb_wrap;
    logic                          up_q;
    logic                          dn_q;
    logic                          ref_tgl_q;
    logic                          fb_tgl_q;
    logic                          test_on;
    logic                          pol;
    logic                          float_on;
    assign pin_in = {vco_in, ref_in, link.chip_enable, link.load_strobe,
                     link.ser_data, link.ser_clk};
    // two-stage synchronisers, edges from second stage only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            prev_q <= '0;
        end
        else
        begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            prev_q <= s2_q;
        end
    end
    assign rise = s2_q & ~prev_q;
    // serial shift register runs in every power mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shift_q <= '0;
        else if (rise[I_SCK])
            shift_q <= {shift_q[ssp_pkg::SR_W-2:0],
                        s2_q[I_SDI]};
    end
    assign word_data = shift_q[ssp_pkg::SR_W-1:1];
    // latches, write only; each keeps its word until the next load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fb_q  <= ssp_pkg::FB_RESET;
            ref_q <= ssp_pkg::REF_RESET;
        end
        else if (rise[I_STB])
        begin
            if (shift_q[ssp_pkg::SEL_BIT] == ssp_pkg::REF_INDEX)
                ref_q <= word_data[ssp_pkg::REF_W-1:0];
            else
                fb_q  <= word_data;
        end
    end

    // field decode
    assign ref_div  =
        ref_q[ssp_pkg::REF_DIV_LSB +: ssp_pkg::DIV_W];
    assign float_on = ref_q[ssp_pkg::REF_FLOAT_BIT];
    assign pol      = ref_q[ssp_pkg::REF_POL_BIT];
    assign test_on  = ref_q[ssp_pkg::REF_TEST_BIT];
    assign ctl      = {fb_q[ssp_pkg::FB_CLR_BIT],
                       fb_q[ssp_pkg::FB_PWR_BIT]};
    assign main_div =
        fb_q[ssp_pkg::FB_MAIN_LSB +: ssp_pkg::DIV_W];
    assign swal_ext = {{(ssp_pkg::DIV_W-ssp_pkg::SWAL_W){1'b0}},
        fb_q[ssp_pkg::FB_SWAL_LSB +: ssp_pkg::SWAL_W]};
    // power control
    assign async_pd  = !s2_q[I_CE] ||
                       (ctl == ssp_pkg::CTL_ASYNC_PD);
    assign sync_req  = s2_q[I_CE] &&
                       (ctl == ssp_pkg::CTL_SYNC_PD);
    assign cnt_clear = s2_q[I_CE] &&
                       (ctl == ssp_pkg::CTL_CLEAR);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            down_q <= 1'b1;
        else if (async_pd)
            down_q <= 1'b1;
        else if (sync_req)
        begin
            if (!up_q && !dn_q)
                down_q <= 1'b1;
        end
        else
            down_q <= 1'b0;
    end

    // counters sit at zero while down or cleared, restart together
    assign hold = down_q || async_pd ||
                  cnt_clear;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            powered_q <= 1'b0;
        else
            powered_q <= !down_q && !async_pd;
    end

    // reference divider
    ssp_modcount #(.W (ssp_pkg::DIV_W)) u_ref_div (
        .pclk    (pclk),
        .presetn (presetn),
        .hold    (hold),
        .tick    (rise[I_REF]),
        .modulus (ref_div),
        .count_q (),
        .wrap    (ref_wrap)
    );

    // prescaler: swallow cycles at 33, remaining at 32
    assign pre_mod = (main_cnt < swal_ext) ? ssp_pkg::PRE_SWALLOW
                                           : ssp_pkg::PRE_PLAIN;

    ssp_modcount #(.W (ssp_pkg::PRE_W)) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .hold    (hold),
        .tick    (rise[I_VCO]),
        .modulus (pre_mod),
        .count_q (),
        .wrap    (pre_wrap)
    );

    ssp_modcount #(.W (ssp_pkg::DIV_W)) u_main_div (
        .pclk    (pclk),
        .presetn (presetn),
        .hold    (hold),
        .tick    (pre_wrap),
        .modulus (main_div),
        .count_q (main_cnt),
        .wrap    (fb_wrap)
    );

    // phase/frequency detector; both high resets next cycle, giving
    // a minimum-width pulse on each side even at zero phase error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else
        begin
            up_q <= !hold && (ref_wrap || (up_q && !dn_q));
            dn_q <= !hold && (fb_wrap || (dn_q && !up_q));
        end
    end

    // divider outputs as square-ish toggles for test routing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_tgl_q   <= 1'b0;
            fb_tgl_q    <= 1'b0;
            ref_pulse_q <= 1'b0;
            fb_pulse_q  <= 1'b0;
        end
        else
        begin
            ref_tgl_q   <= !hold && (ref_tgl_q ^ ref_wrap);
            fb_tgl_q    <= !hold && (fb_tgl_q ^ fb_wrap);
            ref_pulse_q <= ref_wrap;
            fb_pulse_q  <= fb_wrap;
        end
    end

    // pump pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pump_src_q <= 1'b0;
            pump_snk_q <= 1'b0;
            pump_out_q <= 1'b0;
            pump_oe_q  <= 1'b0;
        end
        else if (hold || (float_on && !test_on))
        begin
            pump_src_q <= 1'b0;
            pump_snk_q <= 1'b0;
            pump_out_q <= 1'b0;
            pump_oe_q  <= 1'b0;
        end
        else if (test_on)
        begin
            pump_out_q <= pol ? fb_tgl_q : ref_tgl_q;
            pump_src_q <= pol ? fb_tgl_q : ref_tgl_q;
            pump_snk_q <= pol ? !fb_tgl_q : !ref_tgl_q;
            pump_oe_q  <= 1'b1;
        end
        else
        begin
            pump_src_q <= pol ? up_q : dn_q;
            pump_snk_q <= pol ? dn_q : up_q;
            pump_out_q <= pol ? up_q : dn_q;
            pump_oe_q  <= up_q ^ dn_q;
        end
    end
endmodule : ssp_device
`default_nettype wire

//--- rtl/ssp_pkg.sv
// shared constants for the synthesizer serial port, dividers and host
package ssp_pkg;
    // serial word layout
    localparam int SR_W        = 18;
    localparam int DATA_W      = 17;
    localparam int REF_W       = 14;
    localparam int DIV_W       = 10;
    localparam int SWAL_W      = 5;
    localparam int PRE_W       = 6;
    localparam int SEL_BIT     = 0;
    localparam logic FB_INDEX  = 1'b0;
    localparam logic REF_INDEX = 1'b1;

    // reference register fields, positions within the 17 data bits
    localparam int REF_DIV_LSB   = 0;
    localparam int REF_FLOAT_BIT = 10;
    localparam int REF_POL_BIT   = 11;
    localparam int REF_RSV_BIT   = 12;
    localparam int REF_TEST_BIT  = 13;

    // feedback register fields
    localparam int FB_PWR_BIT  = 0;
    localparam int FB_CLR_BIT  = 1;
    localparam int FB_SWAL_LSB = 2;
    localparam int FB_MAIN_LSB = 7;

    // latch values after reset: pump floated, divider powered off
    localparam logic [REF_W-1:0]  REF_RESET = 14'h0400;
    localparam logic [DATA_W-1:0] FB_RESET  = 17'h00001;

    // power control pair {counter_clear_bit, power_off_bit}
    localparam logic [1:0] CTL_NORMAL   = 2'h0;
    localparam logic [1:0] CTL_SYNC_PD  = 2'h1;
    localparam logic [1:0] CTL_CLEAR    = 2'h2;
    localparam logic [1:0] CTL_ASYNC_PD = 2'h3;

    // dual modulus prescaler
    localparam logic [PRE_W-1:0] PRE_SWALLOW = 6'h21;
    localparam logic [PRE_W-1:0] PRE_PLAIN   = 6'h20;

    // host register map on apb
    localparam int ADDR_W               = 12;
    localparam logic [ADDR_W-1:0] WORD_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h008;
    localparam int CTRL_GO_BIT          = 0;
    localparam int CTRL_CE_BIT          = 1;
    localparam int STAT_BUSY_BIT        = 0;
    localparam logic CE_RESET           = 1'b0;

    // serial timing
    localparam int CLK_NS    = 20;
    localparam int T_CWH_NS  = 50;
    localparam int T_CWL_NS  = 50;
    localparam int T_ES_NS   = 50;
    localparam int T_EW_NS   = 50;
    localparam int TMR_W     = 8;
    localparam int BIT_W     = 5;
    localparam logic [TMR_W-1:0] CWH_CYC =
        TMR_W'((T_CWH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] CWL_CYC =
        TMR_W'((T_CWL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] ES_CYC  =
        TMR_W'((T_ES_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] EW_CYC  =
        TMR_W'((T_EW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(SR_W - 1);
endpackage : ssp_pkg

//--- rtl/ssp_link_if.sv
// three-wire programming link plus chip enable between host and device
`timescale 1ns/100ps
`default_nettype none
interface ssp_link_if;
    logic ser_clk;     // serial clock, made by the host
    logic ser_data;    // serial data, msb first
    logic load_strobe; // rising edge latches the word
    logic chip_enable; // low powers the device down

    modport dev  (input ser_clk, ser_data, load_strobe, chip_enable);
    modport host (output ser_clk, ser_data, load_strobe, chip_enable);
endinterface : ssp_link_if
`default_nettype wire

//--- rtl/ssp_modcount.sv
// modulus counter with hold at zero and wrap pulse
`timescale 1ns/100ps
`default_nettype none
module ssp_modcount #(
    parameter int W = 10
) (
    input  wire logic         pclk,    // system clock
    input  wire logic         presetn, // async reset, active low
    input  wire logic         hold,    // hold at load point (zero)
    input  wire logic         tick,    // count enable pulse
    input  wire logic [W-1:0] modulus, // divide ratio
    output logic      [W-1:0] count_q, // current count
    output logic              wrap     // last tick of a cycle
);
    assign wrap = tick && !hold && (count_q >= modulus - W'(1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= '0;
        else if (hold || wrap)
            count_q <= '0;
        else if (tick)
            count_q <= count_q + W'(1);
    end
endmodule : ssp_modcount
`default_nettype wire

//--- rtl/ssp_host.sv
// apb-controlled host that shifts words into the synthesizer serial port
`timescale 1ns/100ps
`default_nettype none
module ssp_host (
    input  wire logic                       pclk,    // system clock
    input  wire logic                       presetn, // async reset, low
    input  wire logic                       psel,    // apb select
    input  wire logic                       penable, // apb access phase
    input  wire logic                       pwrite,  // apb write
    input  wire logic [ssp_pkg::ADDR_W-1:0] paddr,   // apb byte address
    input  wire logic [31:0]                pwdata,  // apb write data
    output logic      [31:0]                prdata,  // apb read data
    output logic                            pready,  // apb ready
    output logic                            pslverr, // apb error
    ssp_link_if.host                        link     // serial link
);
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_LOW    = 5'b00010,
        ST_HIGH   = 5'b00100,
        ST_GAP    = 5'b01000,
        ST_STROBE = 5'b10000
    } ssp_host_state_t;

    ssp_host_state_t              st_q;
    logic [ssp_pkg::SR_W-1:0]     word_q;
    logic [ssp_pkg::SR_W-1:0]     send_q;
    logic [ssp_pkg::TMR_W-1:0]    tmr_q;
    logic [ssp_pkg::BIT_W-1:0]    bit_q;
    logic                         ce_q;
    logic                         sck_q;
    logic                         sdo_q;
    logic                         stb_q;
    logic                         wr;
    logic                         rd;
    logic                         mapped;
    logic                         go;
    logic                         busy;
    logic                         tmr_done;
    logic [ssp_pkg::SR_W-1:0]     fixed;

    assign busy     = (st_q != ST_IDLE);
    assign mapped   = (paddr == ssp_pkg::WORD_OFS) ||
                      (paddr == ssp_pkg::CTRL_OFS) ||
                      (paddr == ssp_pkg::STAT_OFS);
    assign wr       = psel && penable && pwrite && mapped;
    assign rd       = psel && !penable && !pwrite;
    assign go       = wr && (paddr == ssp_pkg::CTRL_OFS) &&
                      pwdata[ssp_pkg::CTRL_GO_BIT] && !busy;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign tmr_done = (tmr_q == '0);

    // reference words: reserved bit cleared, float forced with test mode
    always_comb
    begin
        fixed = word_q;
        if (word_q[ssp_pkg::SEL_BIT] == ssp_pkg::REF_INDEX)
        begin
            fixed[ssp_pkg::REF_RSV_BIT + 1] = 1'b0;
            if (word_q[ssp_pkg::REF_TEST_BIT + 1])
                fixed[ssp_pkg::REF_FLOAT_BIT + 1] = 1'b1;
        end
    end

    // registers; the word is refused while a transfer runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_q <= '0;
            ce_q   <= ssp_pkg::CE_RESET;
        end
        else if (wr && paddr == ssp_pkg::WORD_OFS && !busy)
            word_q <= pwdata[ssp_pkg::SR_W-1:0];
        else if (wr && paddr == ssp_pkg::CTRL_OFS)
            ce_q   <= pwdata[ssp_pkg::CTRL_CE_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (rd)
        begin
            prdata <= '0;
            if (paddr == ssp_pkg::WORD_OFS)
                prdata[ssp_pkg::SR_W-1:0] <= word_q;
            else if (paddr == ssp_pkg::CTRL_OFS)
                prdata[ssp_pkg::CTRL_CE_BIT] <= ce_q;
            else if (paddr == ssp_pkg::STAT_OFS)
                prdata[ssp_pkg::STAT_BUSY_BIT] <= busy;
        end
    end

    // serial sequencer: data during clock low, msb first, then strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q   <= ST_IDLE;
            send_q <= '0;
            tmr_q  <= '0;
            bit_q  <= '0;
            sck_q  <= 1'b0;
            sdo_q  <= 1'b0;
            stb_q  <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                    if (go)
                    begin
                        send_q <= {fixed[ssp_pkg::SR_W-2:0], 1'b0};
                        sdo_q  <= fixed[ssp_pkg::SR_W-1];
                        bit_q  <= '0;
                        tmr_q  <= ssp_pkg::CWL_CYC;
                        st_q   <= ST_LOW;
                    end
                ST_LOW:
                    if (tmr_done)
                    begin
                        sck_q <= 1'b1;
                        tmr_q <= ssp_pkg::CWH_CYC;
                        st_q  <= ST_HIGH;
                    end
                    else
                        tmr_q <= tmr_q - ssp_pkg::TMR_W'(1);
                ST_HIGH:
                    if (tmr_done)
                    begin
                        sck_q <= 1'b0;
                        if (bit_q == ssp_pkg::LAST_BIT)
                        begin
                            tmr_q <= ssp_pkg::ES_CYC;
                            st_q  <= ST_GAP;
                        end
                        else
                        begin
                            sdo_q  <= send_q[ssp_pkg::SR_W-1];
                            send_q <= {send_q[ssp_pkg::SR_W-2:0], 1'b0};
                            bit_q  <= bit_q + ssp_pkg::BIT_W'(1);
                            tmr_q  <= ssp_pkg::CWL_CYC;
                            st_q   <= ST_LOW;
                        end
                    end
                    else
                        tmr_q <= tmr_q - ssp_pkg::TMR_W'(1);
                ST_GAP:
                    if (tmr_done)
                    begin
                        stb_q <= 1'b1;
                        tmr_q <= ssp_pkg::EW_CYC;
                        st_q  <= ST_STROBE;
                    end
                    else
                        tmr_q <= tmr_q - ssp_pkg::TMR_W'(1);
                ST_STROBE:
                    if (tmr_done)
                    begin
                        stb_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                    else
                        tmr_q <= tmr_q - ssp_pkg::TMR_W'(1);
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    assign link.ser_clk     = sck_q;
    assign link.ser_data    = sdo_q;
    assign link.load_strobe = stb_q;
    assign link.chip_enable = ce_q;
endmodule : ssp_host
`default_nettype wire

//--- tb/ssp_sva.sv
// link timing checks between host and device
`timescale 1ns/100ps
`default_nettype none
module ssp_sva (
    input wire logic pclk,        // clock
    input wire logic presetn,     // reset, low
    input wire logic ser_clk,     // serial clock
    input wire logic ser_data,    // serial data
    input wire logic load_strobe, // latch strobe
    input wire logic chip_enable  // enable
);
    logic       sc_q;   // serial clock last cycle
    logic [4:0] rise_q; // clock rises since strobe
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sc_q <= 1'b0;
        else sc_q <= ser_clk;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) rise_q <= 5'h00;
        else if (load_strobe) rise_q <= 5'h00;
        else if (ser_clk && !sc_q) rise_q <= rise_q + 5'h01;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_hi; ser_clk [*4]; endsequence
    sequence s_lo; !ser_clk [*3]; endsequence
    sequence s_stb; load_strobe [*4] ##1 !load_strobe; endsequence
    a_clk_high: assert property ($rose(ser_clk) |-> s_hi)
        else $error("clock high short");
    a_clk_low: assert property ($fell(ser_clk) |-> s_lo)
        else $error("clock low short");
    a_data_hold: assert property (ser_clk |-> $stable(ser_data))
        else $error("data moved");
    a_data_setup: assert property (
        $rose(ser_clk) |-> $past(ser_data, 3) == ser_data)
        else $error("data setup short");
    a_frame_len: assert property (
        $rose(load_strobe) |-> rise_q == 5'h12)
        else $error("frame not 18 bits");
    a_stb_width: assert property ($rose(load_strobe) |-> s_stb)
        else $error("strobe width");
    a_stb_setup: assert property (
        $rose(load_strobe) |-> !$past(ser_clk, 3))
        else $error("strobe too soon");
    a_stb_quiet: assert property (load_strobe |-> !ser_clk)
        else $error("clock during strobe");
endmodule : ssp_sva
`default_nettype wire

//--- tb/synth_serial_program_and_dividers_test.sv
// host and device joined over the link, checked against an integer model
`timescale 1ns/100ps
`default_nettype none
module synth_serial_program_and_dividers_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, ref_in = 1'b0;
    logic        vco_in = 1'b0, pready, pslverr, pump_out_q, pump_oe_q;
    logic        pump_src_q, pump_snk_q, ref_pulse_q, fb_pulse_q;
    logic        powered_q, e, v;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0]  div_q = 4'h0;
    int          num_errors = 0, checked = 0, r, b, a, n, oe_n, pl_n;
    int          exp_q[$];
    ssp_link_if link ();
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        div_q <= div_q + 4'h1;
        vco_in <= div_q[1];
        ref_in <= div_q[2];
    end
    ssp_host i_ssp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    ssp_device i_ssp_device (.pclk(pclk), .presetn(presetn), .link(link),
        .ref_in(ref_in), .vco_in(vco_in), .pump_out_q(pump_out_q),
        .pump_oe_q(pump_oe_q), .pump_src_q(pump_src_q),
        .pump_snk_q(pump_snk_q), .ref_pulse_q(ref_pulse_q),
        .fb_pulse_q(fb_pulse_q), .powered_q(powered_q));
    ssp_sva i_ssp_sva (.pclk(pclk), .presetn(presetn),
        .ser_clk(link.ser_clk), .ser_data(link.ser_data),
        .load_strobe(link.load_strobe), .chip_enable(link.chip_enable));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic send(input logic [17:0] w, input logic ce);
        int k;
        k = 0;
        apb(1'b1, ssp_pkg::WORD_OFS, {14'h0, w}, q, e);
        apb(1'b1, ssp_pkg::CTRL_OFS, {30'h0, ce, 1'b1}, q, e);
        q = 32'h1;
        while (q[0] !== 1'b0 && k < 300)
        begin
            apb(1'b0, ssp_pkg::STAT_OFS, 32'h0, q, e);
            k++;
        end
        repeat (6) @(posedge pclk);
    endtask : send
    // cycles until the next divider pulse
    task automatic wait_pulse(input logic fb, output int c);
        @(negedge pclk);
        c = 0;
        while ((fb ? fb_pulse_q : ref_pulse_q) !== 1'b1 && c < 3000)
        begin
            @(negedge pclk);
            c++;
        end
    endtask : wait_pulse
    task automatic watch(output int oe_c, output int pl_c, output int bo_c);
        oe_c = 0;
        pl_c = 0;
        bo_c = 0;
        repeat (1000)
        begin
            @(negedge pclk);
            if (pump_oe_q !== 1'b0) oe_c++;
            if ((ref_pulse_q | fb_pulse_q) !== 1'b0) pl_c++;
            if ((pump_src_q & pump_snk_q) === 1'b1) bo_c++;
        end
    endtask : watch
    task automatic final_report;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    initial
    begin
        #1000000;
        num_errors++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'he7f7c95e));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        apb(1'b1, ssp_pkg::CTRL_OFS, 32'h2, q, e);
        apb(1'b0, ssp_pkg::CTRL_OFS, 32'h0, q, e);
        check(q, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            r = 2 + $urandom % 8;
            b = 3 + $urandom % 4;
            a = $urandom % (b + 1);
            v = i[0];
            exp_q.push_back(8 * r);
            exp_q.push_back(4 * (32 * b + a));
            send({3'($urandom), 2'h0, v, 1'b0, 10'(r), 1'b1}, 1'b1);
            send({10'(b), 5'(a), 3'h0}, 1'b1);
            wait_pulse(1'b0, n);
            wait_pulse(1'b0, n);
            check(32'(n + 1), exp_q.pop_front());
            wait_pulse(1'b1, n);
            wait_pulse(1'b1, n);
            check(32'(n + 1), exp_q.pop_front());
            watch(oe_n, pl_n, n);
            check(32'(n > 0), 32'h1);
            $display("test %0d done", i);
        end
        for (int p = 0; p < 2; p++)
        begin
            send({5'h02, 1'(p), 1'b1, 10'(r), 1'b1}, 1'b1);
            wait_pulse(1'(p), n);
            repeat (4) @(negedge pclk);
            v = pump_out_q;
            wait_pulse(1'(p), n);
            repeat (4) @(negedge pclk);
            check({31'h0, pump_out_q}, {31'h0, ~v});
            check({31'h0, pump_oe_q}, 32'h1);
        end
        send({7'h01, 10'(r), 1'b1}, 1'b1);
        watch(oe_n, pl_n, n);
        check(32'(oe_n), 32'h0);
        send({7'h02, 10'(r), 1'b1}, 1'b1);
        for (int c = 1; c < 5; c++)
        begin
            if (c < 4)
                send({10'(b), 5'(a), 2'(c), 1'b0}, 1'b1);
            else
            begin
                send({10'(b), 5'(a), 3'h0}, 1'b0);
                send({7'h02, 10'(r + 1), 1'b1}, 1'b0);
            end
            repeat (1000) @(negedge pclk);
            watch(oe_n, pl_n, n);
            check(32'(oe_n + pl_n), 32'h0);
            $display("power mode %0d done", c);
        end
        apb(1'b1, ssp_pkg::CTRL_OFS, 32'h2, q, e);
        wait_pulse(1'b0, n);
        wait_pulse(1'b0, n);
        check(32'(n + 1), 32'(8 * (r + 1)));
        check({31'h0, powered_q}, 32'h1);
        final_report();
    end
endmodule : synth_serial_program_and_dividers_test
`default_nettype wire
